/* design/sab_bus_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module sab_bus_ctrl
  import sab_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_io,
  input  wire logic [23:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             busy,
  output logic             resp_done,
  output logic             resp_hit,
  output logic      [7:0]  resp_rdata,
  output logic      [23:0] addr_out,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  input  wire logic [7:0]  data_in,
  output logic             read_not_write,
  output logic             address_strobe_n,
  output logic             data_strobe_n,
  input  wire logic        transfer_ack_n,
  output logic      [3:0]  chip_sel_n
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_SWITCH, ST_NATIVE, ST_SEP,
    ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_S5, ST_S6, ST_S7, ST_WAIT
  } sab_state_t;

  logic [7:0]  range_low_byte  [4];
  logic [7:0]  range_high_byte [4];
  logic [7:0]  ctrl            [4];
  logic [7:0]  mode            [4];
  sab_state_t  state;
  sab_state_t  next_state;
  logic [6:0]  cnt;
  logic [6:0]  state_len;
  logic        last;
  logic        ack_q;
  sab_mode_t   prev_cls;
  sab_mode_t   cur_cls;
  sab_mode_t   req_cls;
  logic        need_switch;
  logic        cur_write;
  logic        cur_hit;
  logic [1:0]  cur_sel;
  logic [23:0] cur_addr;
  logic [7:0]  cur_wdata;
  logic [3:0]  cur_len;
  logic [2:0]  cur_wait;
  logic        enter;
  logic        finish;

  sab_sel_if sel_bus ();

  // ==========================================================
  // Helpers
  function automatic sab_mode_t mode_class(input logic [7:0] m);
    return sab_mode_t'(m[MODE_SEL_LSB +: 2]);
  endfunction : mode_class

  function automatic logic is_native(input sab_mode_t c);
    return c == SAB_NATIVE || c == SAB_NATIVE_ALT;
  endfunction : is_native

  // ==========================================================
  // Select decode
  assign sel_bus.addr      = req_addr;
  assign sel_bus.io_access = req_io;
  for (genvar k = 0; k < 4; k++) begin : g_map
    assign sel_bus.range_low_byte[k]  = range_low_byte[k];
    assign sel_bus.range_high_byte[k] = range_high_byte[k];
    assign sel_bus.ctrl[k]            = ctrl[k];
  end

  sab_sel_decode u_dec (
    .s (sel_bus.dec_side)
  );

  assign req_cls     = sel_bus.hit ? mode_class(mode[sel_bus.sel]) : SAB_NATIVE;
  // Only moves onto a non-native protocol cost a cycle
  assign need_switch = !is_native(req_cls) && req_cls != prev_cls;

  // ==========================================================
  // APB slave, one wait cycle per access
  wire       apb_acc = psel && penable && pready;
  wire [9:0] idx     = paddr[11:2];

  function automatic logic [4:0] reg_decode(input logic [9:0] i);
    // {valid, kind[1:0], select[1:0]}; kind 0 low, 1 high, 2 ctrl, 3 mode
    reg_decode = 5'h00;
    for (int k = 0; k < 4; k++) begin
      if (i == IDX_SELECT0_RANGE_LOW + 10'(k) * IDX_SELECT_STRIDE) begin
        reg_decode = {3'b100, k[1:0]};
      end
      if (i == IDX_SELECT0_RANGE_LOW + 10'(k) * IDX_SELECT_STRIDE + IDX_RANGE_HIGH_OFS) begin
        reg_decode = {3'b101, k[1:0]};
      end
      if (i == IDX_SELECT0_RANGE_LOW + 10'(k) * IDX_SELECT_STRIDE + IDX_CTRL_OFS) begin
        reg_decode = {3'b110, k[1:0]};
      end
      if (i == IDX_MODE_BASE + 10'(k)) begin
        reg_decode = {3'b111, k[1:0]};
      end
    end
  endfunction : reg_decode

  wire [4:0] dec_hit = reg_decode(idx);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !dec_hit[4] && idx != IDX_STATUS;
      if (psel && penable && !pready) begin
        prdata <= 32'h0000_0000;
        if (idx == IDX_STATUS) begin
          prdata <= {24'h00_0000, busy, cur_hit, cur_sel, prev_cls, cur_cls};
        end else if (dec_hit[4]) begin
          unique case (dec_hit[3:2])
            2'h0: prdata[7:0] <= range_low_byte[dec_hit[1:0]];
            2'h1: prdata[7:0] <= range_high_byte[dec_hit[1:0]];
            2'h2: prdata[7:0] <= ctrl[dec_hit[1:0]];
            2'h3: prdata[7:0] <= mode[dec_hit[1:0]];
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 4; k++) begin
        range_low_byte[k]  <= RST_RANGE_LOW;
        range_high_byte[k] <= (k == 0) ? RST_RANGE_HIGH0 : RST_RANGE_HIGH;
        ctrl[k]            <= (k == 0) ? RST_CTRL0 : RST_CTRL;
        mode[k]            <= RST_MODE;
      end
    end else if (apb_acc && pwrite && dec_hit[4]) begin
      unique case (dec_hit[3:2])
        2'h0: range_low_byte[dec_hit[1:0]]  <= pwdata[7:0];
        2'h1: range_high_byte[dec_hit[1:0]] <= pwdata[7:0];
        2'h2: ctrl[dec_hit[1:0]]            <= pwdata[7:0] & CTRL_WR_MASK;
        2'h3: mode[dec_hit[1:0]]            <= pwdata[7:0] & MODE_WR_MASK;
      endcase
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    unique case (state)
      ST_NATIVE: state_len = 7'(cur_wait) + 7'h01;
      ST_SEP:    state_len = 7'(cur_len) * 7'(SEP_STATES);
      ST_SWITCH: state_len = 7'(SWITCH_CYCLES);
      default:   state_len = 7'(cur_len);
    endcase
  end

  assign last = cnt >= state_len - 7'h01;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (req_valid) begin
          if (need_switch) begin
            next_state = ST_SWITCH;
          end else if (req_cls == SAB_STROBE_ACK) begin
            next_state = ST_S0;
          end else if (req_cls == SAB_SEP_STROBE) begin
            next_state = ST_SEP;
          end else begin
            next_state = ST_NATIVE;
          end
        end
      end
      ST_SWITCH: begin
        if (cur_cls == SAB_STROBE_ACK) begin
          next_state = ST_S0;
        end else begin
          next_state = ST_SEP;
        end
      end
      ST_NATIVE, ST_SEP, ST_S7: if (last) next_state = ST_IDLE;
      ST_S0: if (last) next_state = ST_S1;
      ST_S1: if (last) next_state = ST_S2;
      ST_S2: if (last) next_state = ST_S3;
      ST_S3: if (last) next_state = ST_S4;
      // Acknowledge is seen through ack_q, a full clock before the edge
      ST_S4, ST_WAIT: if (last) next_state = ack_q ? ST_S5 : ST_WAIT;
      ST_S5: if (last) next_state = ST_S6;
      ST_S6: if (last) next_state = ST_S7;
    endcase
  end

  assign enter  = next_state != state || (state == ST_WAIT && last);
  assign finish = state != ST_IDLE && next_state == ST_IDLE;

  // Taking edge has not loaded the cur_ copies yet, so pins read the request
  wire        from_idle = state == ST_IDLE;
  wire [23:0] pin_addr  = from_idle ? req_addr : cur_addr;
  wire [7:0]  pin_wdata = from_idle ? req_wdata : cur_wdata;
  wire        pin_write = from_idle ? req_write : cur_write;
  wire [3:0]  pin_cs_n  = from_idle ? ~(4'(sel_bus.hit) << sel_bus.sel) : ~(4'(cur_hit) << cur_sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt   <= 7'h00;
      ack_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= enter ? 7'h00 : cnt + 7'h01;
      ack_q <= !transfer_ack_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_cls  <= SAB_NATIVE;
      cur_cls   <= SAB_NATIVE;
      cur_write <= 1'b0;
      cur_hit   <= 1'b0;
      cur_sel   <= 2'h0;
      cur_addr  <= 24'h00_0000;
      cur_wdata <= 8'h00;
      cur_len   <= STATE_LEN_MIN;
      cur_wait  <= 3'h0;
    end else if (state == ST_IDLE && req_valid) begin
      prev_cls  <= req_cls;
      cur_cls   <= req_cls;
      cur_write <= req_write;
      cur_hit   <= sel_bus.hit;
      cur_sel   <= sel_bus.sel;
      cur_addr  <= req_addr;
      cur_wdata <= req_wdata;
      // Zero length is illegal; it runs as one cycle rather than hang
      cur_len   <= (mode[sel_bus.sel][3:0] == STATE_LEN_INVALID || !sel_bus.hit)
                   ? STATE_LEN_MIN : mode[sel_bus.sel][3:0];
      // Fixed waits only apply to native selects
      cur_wait  <= (sel_bus.hit && is_native(req_cls))
                   ? ctrl[sel_bus.sel][CTRL_WAIT_LSB +: 3] : 3'h0;
    end
  end

  // ==========================================================
  // Pin driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_out         <= 24'h00_0000;
      data_out         <= 8'h00;
      data_oe          <= 1'b0;
      read_not_write   <= 1'b1;
      address_strobe_n <= 1'b1;
      data_strobe_n    <= 1'b1;
      chip_sel_n       <= 4'hF;
    end else if (enter) begin
      unique case (next_state)
        ST_S0: begin
          read_not_write <= 1'b1;
          chip_sel_n     <= pin_cs_n;
        end
        ST_S1: addr_out <= cur_addr;
        ST_S2: begin
          address_strobe_n <= 1'b0;
          data_strobe_n    <= cur_write;
          read_not_write   <= !cur_write;
        end
        ST_S3: begin
          if (cur_write) begin
            data_out <= cur_wdata;
            data_oe  <= 1'b1;
          end
        end
        ST_S4: data_strobe_n <= 1'b0;
        ST_S7: begin
          address_strobe_n <= 1'b1;
          data_strobe_n    <= 1'b1;
        end
        ST_NATIVE, ST_SEP: begin
          addr_out       <= pin_addr;
          chip_sel_n     <= pin_cs_n;
          read_not_write <= !pin_write;
          data_out       <= pin_wdata;
          data_oe        <= pin_write;
        end
        ST_IDLE: begin
          read_not_write <= 1'b1;
          data_oe        <= 1'b0;
          chip_sel_n     <= 4'hF;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Answer to the CPU side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      resp_done  <= 1'b0;
      resp_hit   <= 1'b0;
      resp_rdata <= 8'h00;
    end else begin
      busy      <= next_state != ST_IDLE;
      resp_done <= finish;
      resp_hit  <= finish ? cur_hit : resp_hit;
      // Peripheral data valid through S6 is latched on entry to S7
      if (!cur_write && ((state == ST_S6 && next_state == ST_S7) || (finish && state != ST_S7))) begin
        resp_rdata <= data_in;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enter_s7_read;
    state == ST_S6 && next_state == ST_S7 && !cur_write;
  endsequence
  sequence s_late_ack;
    (state == ST_S4 || state == ST_WAIT) && last && !ack_q;
  endsequence

  a_read_latch_neg: assert property (s_enter_s7_read |=> address_strobe_n && data_strobe_n
    && resp_rdata == $past(data_in)) else $error("read end strobes or data wrong");
  a_write_s0_rnw: assert property (state == ST_IDLE && next_state == ST_S0 |=> read_not_write)
    else $error("S0 did not raise read line");
  a_write_as_low: assert property (state == ST_S1 && next_state == ST_S2 && cur_write
    |=> !address_strobe_n && !read_not_write && data_strobe_n) else $error("S2 write pins wrong");
  a_write_data_on: assert property (state == ST_S2 && next_state == ST_S3 && cur_write
    |=> data_oe && data_out == cur_wdata) else $error("S3 data not driven");
  a_ds_in_s4: assert property (state == ST_S3 && next_state == ST_S4 |=> !data_strobe_n)
    else $error("S4 data strobe missing");
  a_wait_insert: assert property (s_late_ack |=> state == ST_WAIT && cnt == 7'h00)
    else $error("late acknowledge not stretched");
  a_wait_full: assert property (state == ST_WAIT && !last |=> state == ST_WAIT)
    else $error("wait state cut short");
  a_s5s6_hold: assert property ((state == ST_S5 || state == ST_S6) && next_state != ST_S7
    |=> $stable({address_strobe_n, data_strobe_n, read_not_write, addr_out, data_oe}))
    else $error("bus moved in S5/S6");
  a_rnw_return: assert property (state == ST_S7 && finish |=> read_not_write && !data_oe)
    else $error("read line not restored");
  a_switch_add: assert property (state == ST_IDLE && req_valid && !is_native(req_cls)
    |=> (state == ST_SWITCH) == $past(req_cls != prev_cls)) else $error("switch cycle wrong");
  a_native_nosw: assert property (state == ST_IDLE && req_valid && is_native(req_cls)
    |=> state == ST_NATIVE) else $error("native access got extra cycle");
endmodule : sab_bus_ctrl
`default_nettype wire

/* design/sab_pkg.sv */
package sab_pkg;
  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam logic [9:0] IDX_SELECT0_RANGE_LOW  = 10'h0A8;
  localparam logic [9:0] IDX_SELECT1_RANGE_LOW  = 10'h0AB;
  localparam logic [9:0] IDX_SELECT2_RANGE_LOW  = 10'h0AE;
  localparam logic [9:0] IDX_SELECT3_RANGE_LOW  = 10'h0B1;
  localparam logic [9:0] IDX_RANGE_HIGH_OFS     = 10'h001;
  localparam logic [9:0] IDX_CTRL_OFS           = 10'h002;
  localparam logic [9:0] IDX_SELECT_STRIDE      = 10'h003;
  localparam logic [9:0] IDX_MODE_BASE          = 10'h0F0;
  localparam logic [9:0] IDX_STATUS             = 10'h080;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_RANGE_LOW          = 8'h00;
  localparam logic [7:0] RST_RANGE_HIGH0        = 8'hFF;
  localparam logic [7:0] RST_RANGE_HIGH         = 8'h00;
  localparam logic [7:0] RST_CTRL0              = 8'hE8;
  localparam logic [7:0] RST_CTRL               = 8'h00;
  localparam logic [7:0] RST_MODE               = 8'h02;
  // ==========================================================
  // Field layout
  localparam int         CTRL_WAIT_LSB          = 5;
  localparam int         CTRL_IO_BIT            = 4;
  localparam int         CTRL_EN_BIT            = 3;
  localparam logic [7:0] CTRL_WR_MASK           = 8'hF8;
  localparam logic [7:0] MODE_WR_MASK           = 8'hEF;
  localparam int         MODE_SEL_LSB           = 6;
  localparam logic [3:0] STATE_LEN_INVALID      = 4'h0;
  localparam logic [3:0] STATE_LEN_MIN          = 4'h1;
  localparam int         SEP_STATES             = 4;
  localparam int         SWITCH_CYCLES          = 1;
  // ==========================================================
  // Protocol classes
  typedef enum logic [1:0] {
    SAB_NATIVE,
    SAB_NATIVE_ALT,
    SAB_SEP_STROBE,
    SAB_STROBE_ACK
  } sab_mode_t;
endpackage : sab_pkg

/* design/sab_sel_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sab_sel_if;
  logic [23:0] addr;
  logic        io_access;
  logic [7:0]  range_low_byte [4];
  logic [7:0]  range_high_byte [4];
  logic [7:0]  ctrl [4];
  logic        hit;
  logic [1:0]  sel;
  modport ctrl_side (output addr, io_access, range_low_byte, range_high_byte, ctrl, input hit, sel);
  modport dec_side (input addr, io_access, range_low_byte, range_high_byte, ctrl, output hit, sel);
endinterface : sab_sel_if
`default_nettype wire

/* design/sab_sel_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module sab_sel_decode
  import sab_pkg::*;
(
  sab_sel_if.dec_side s
);
  logic [3:0] match;

  // ==========================================================
  // Per-select address compare
  for (genvar k = 0; k < 4; k++) begin : g_sel
    wire en_k = s.ctrl[k][CTRL_EN_BIT];
    wire io_k = s.ctrl[k][CTRL_IO_BIT];
    assign match[k] = en_k && (io_k
      ? (s.io_access && s.addr[15:8] == s.range_low_byte[k])
      : (!s.io_access && s.addr[23:16] >= s.range_low_byte[k]
         && s.addr[23:16] <= s.range_high_byte[k]));
  end

  // Lowest select wins when ranges overlap
  always_comb begin
    s.hit = |match;
    s.sel = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (match[k]) begin
        s.sel = k[1:0];
      end
    end
  end
endmodule : sab_sel_decode
`default_nettype wire

/* dv/sab_periph_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sab_periph_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       address_strobe_n,
  input  wire logic       data_strobe_n,
  input  wire logic       read_not_write,
  input  wire logic [3:0] ack_delay,
  input  wire logic [7:0] rd_value,
  output logic            transfer_ack_n,
  output logic      [7:0] data_in
);
  // ==========================================================
  // Acknowledge, counted from address strobe
  logic [3:0] wait_cnt;
  logic       ack_q;
  logic [7:0] last_data;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      ack_q    <= 1'b1;
    end else if (address_strobe_n) begin
      wait_cnt <= 4'h0;
      ack_q    <= 1'b1;
    end else if (wait_cnt >= ack_delay) begin
      ack_q <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  // Let go at once when address strobe negates, not an edge later
  assign transfer_ack_n = ack_q | address_strobe_n;
  // ==========================================================
  // Data bus, changing pattern while released
  assign data_in = (read_not_write && !data_strobe_n) ? rd_value : ~last_data;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_data <= 8'h00;
    else          last_data <= data_in;
  end
endmodule : sab_periph_model
`default_nettype wire

/* dv/test_sab_bus_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_sab_bus_ctrl;
  import sab_pkg::*;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        req_valid, req_write, req_io, busy, resp_done, resp_hit;
  logic [23:0] req_addr, addr_out;
  logic [7:0]  req_wdata, resp_rdata, data_out, data_in, rd_value;
  logic        data_oe, read_not_write, address_strobe_n, data_strobe_n, transfer_ack_n;
  logic [3:0]  chip_sel_n, ack_delay;
  int          error_cnt, compares;

  sab_bus_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_write(req_write), .req_io(req_io), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .resp_done(resp_done), .resp_hit(resp_hit),
    .resp_rdata(resp_rdata), .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .read_not_write(read_not_write), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .transfer_ack_n(transfer_ack_n), .chip_sel_n(chip_sel_n));

  sab_periph_model u_periph (.pclk(pclk), .presetn(presetn), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .read_not_write(read_not_write), .ack_delay(ack_delay),
    .rd_value(rd_value), .transfer_ack_n(transfer_ack_n), .data_in(data_in));

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready_seen", 0, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // Idle cycle so the next call never re-drives psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic wr_reg(input logic [9:0] idx, input logic [7:0] val);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, idx, {24'h000000, val}, rd, err);
  endtask : wr_reg

  task automatic access(input logic wr, input logic io, input logic [23:0] a, input logic [7:0] wd,
                        output int total, output int as_at, output int ds_at, output logic [3:0] sel);
    int n;
    n = 0; as_at = -1; ds_at = -1; sel = 4'hF;
    req_valid <= 1'b1; req_write <= wr; req_io <= io; req_addr <= a; req_wdata <= wd;
    do begin
      @(posedge pclk);
      n++;
      if (busy === 1'b1) req_valid <= 1'b0;
      if (as_at < 0 && address_strobe_n === 1'b0) begin
        as_at = n;
        sel = chip_sel_n;
        check("addr_out", addr_out, a);
      end
      if (ds_at < 0 && data_strobe_n === 1'b0) begin
        ds_at = n;
        if (wr) check("write_data", {data_oe, data_out}, {1'b1, wd});
      end
    end while (resp_done !== 1'b1 && n < 200);
    if (n >= 200) check("done_seen", 0, 1);
    total = n;
    @(posedge pclk);
  endtask : access

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [9:0]  offs [4];
    logic [31:0] rd;
    logic        err;
    offs = '{10'h0A8, 10'h0AB, 10'h0AE, 10'h0B1};
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, offs[k], 32'h0, rd, err);
      check("range_low_rst", rd, 32'h00);
      wr_reg(offs[k], 8'h5A + 8'(k));
      apb(1'b0, offs[k], 32'h0, rd, err);
      check("range_low_rw", rd, 32'h5A + 32'(k));
    end
    apb(1'b0, 10'h3FF, 32'h0, rd, err);
    check("unmapped_rd", rd, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
  endtask : t_regs

  task automatic t_switch();
    int t1, t2, t3, n1, n2, a, d;
    logic [3:0] s;
    wr_reg(IDX_SELECT0_RANGE_LOW + IDX_CTRL_OFS, 8'h00);
    wr_reg(IDX_SELECT1_RANGE_LOW, 8'h40);
    wr_reg(IDX_SELECT1_RANGE_LOW + IDX_RANGE_HIGH_OFS, 8'h4F);
    // Fixed waits of 7 must not lengthen a strobe-ack access
    wr_reg(IDX_SELECT1_RANGE_LOW + IDX_CTRL_OFS, 8'hE8);
    wr_reg(IDX_MODE_BASE + 10'h001, 8'hC1);
    access(1'b1, 1'b0, 24'h451234, 8'h3C, t1, a, d, s);
    access(1'b1, 1'b0, 24'h4F00FF, 8'hC3, t2, a, d, s);
    check("switch_extra", t1 - t2, SWITCH_CYCLES);
    check("strobe_gap", d - a, 2);
    check("as_to_done", t2 - a, 6);
    check("sel_mem", s, 4'b1101);
    check("rnw_idle", read_not_write, 1'b1);
    access(1'b1, 1'b0, 24'h500000, 8'h11, n1, a, d, s);
    check("hit_above", resp_hit, 1'b0);
    access(1'b0, 1'b0, 24'h3FFFFF, 8'h00, n2, a, d, s);
    check("hit_below", resp_hit, 1'b0);
    check("native_return", n1, n2);
    access(1'b1, 1'b0, 24'h400000, 8'h77, t3, a, d, s);
    check("native_to_ack", t3 - t2, SWITCH_CYCLES);
  endtask : t_switch

  task automatic t_read();
    int t, a, d;
    logic [3:0] s;
    rd_value <= 8'hA5;
    access(1'b0, 1'b0, 24'h401000, 8'h00, t, a, d, s);
    check("read_strobes", d - a, 0);
    check("read_data", resp_rdata, 8'hA5);
    check("read_hit", resp_hit, 1'b1);
  endtask : t_read

  task automatic t_io();
    int t, t2, a, d;
    logic [3:0] s;
    wr_reg(IDX_SELECT2_RANGE_LOW, 8'h12);
    wr_reg(IDX_SELECT2_RANGE_LOW + IDX_CTRL_OFS, 8'h18);
    wr_reg(IDX_MODE_BASE + 10'h002, 8'hC1);
    access(1'b0, 1'b1, 24'hFF1234, 8'h00, t, a, d, s);
    check("io_hit", {resp_hit, s}, {1'b1, 4'b1011});
    access(1'b0, 1'b1, 24'h001334, 8'h00, t, a, d, s);
    check("io_miss", resp_hit, 1'b0);
    // Separate-strobe after native pays the switch cycle, a repeat does not
    wr_reg(IDX_MODE_BASE + 10'h002, 8'h81);
    access(1'b0, 1'b1, 24'hFF1234, 8'h00, t, a, d, s);
    access(1'b0, 1'b1, 24'h001234, 8'h00, t2, a, d, s);
    check("sep_switch", t - t2, SWITCH_CYCLES);
    check("sep_hit", resp_hit, 1'b1);
  endtask : t_io

  task automatic t_waits();
    int tf, ts, a, d;
    logic [3:0] s;
    wr_reg(IDX_MODE_BASE + 10'h001, 8'hC2);
    access(1'b1, 1'b0, 24'h420000, 8'h01, tf, a, d, s);
    ack_delay <= 4'h9;
    access(1'b1, 1'b0, 24'h420001, 8'h02, ts, a, d, s);
    check("wait_added", ts > tf, 1'b1);
    // First access paid a switch cycle, the second did not
    check("wait_whole_state", (ts - tf + SWITCH_CYCLES) % 2, 0);
    ack_delay <= 4'h0;
  endtask : t_waits

  // ==========================================================
  // Run
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    #(30000 * 4);
    error_cnt++;
    complete_run();
  end

  initial begin
    error_cnt = 0; compares = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    req_valid = 1'b0; req_write = 1'b0; req_io = 1'b0; req_addr = 24'h0; req_wdata = 8'h00;
    ack_delay = 4'h0; rd_value = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_switch();
    t_read();
    t_io();
    t_waits();
    complete_run();
  end
endmodule : test_sab_bus_ctrl
`default_nettype wire
